// File: rtl/irq_cfg.svh
// constants for the interrupt flag and supply monitor block
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define MON_IRQ_DELAY_NS 15000
`define MON_IRQ_DELAY_CYC ((`MON_IRQ_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MON_CNT_W 16
// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define AXI_ADDR_W 8
`define REG_MON_CTRL 8'h00
`define REG_EDGE_SEL 8'h04
`define REG_IRQ_FIRST 8'h08
`define REG_IRQ_SECOND 8'h0C
`define REG_IRQ_THIRD 8'h10
`define REG_RESET 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// ----------------------------------------
// sources and default priority, slot 0 highest, 3 bits per slot
// ----------------------------------------
`define NUM_SRC 8
`define SRC_IDX_W 3
`define DEFAULT_PRIO 24'hFAC688
`endif

// File: rtl/irq_pkg.sv
// types shared by the interrupt flag and supply monitor block
package irq_pkg;
    typedef enum logic [1:0] {
        EDGE_OFF = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_mode_t;

    typedef enum logic [2:0] {
        LVL_1V8 = 3'b000,
        LVL_2V0 = 3'b001,
        LVL_2V4 = 3'b010,
        LVL_2V7 = 3'b011,
        LVL_3V0 = 3'b100,
        LVL_3V3 = 3'b101,
        LVL_3V6 = 3'b110,
        LVL_4V0 = 3'b111
    } trip_level_t;

    typedef enum logic [2:0] {
        SRC_PIN0 = 3'b000,
        SRC_PIN1 = 3'b001,
        SRC_TIMEBASE = 3'b010,
        SRC_POWER_SWITCH = 3'b011,
        SRC_MONITOR = 3'b100,
        SRC_EEPROM = 3'b101,
        SRC_CMP_A = 3'b110,
        SRC_CMP_P = 3'b111
    } src_id_t;

    typedef enum logic [1:0] {
        MON_IDLE = 2'b00,
        MON_COUNT = 2'b01,
        MON_FIRED = 2'b10
    } mon_state_t;

    typedef struct packed {
        logic [1:0] rsv_hi;
        logic low_supply_output;
        logic monitor_enable;
        logic rsv_mid;
        trip_level_t trip_level_select;
    } mon_ctrl_t;

    typedef struct packed {
        logic [3:0] rsv_hi;
        edge_mode_t pin1_edge_field;
        edge_mode_t pin0_edge_field;
    } edge_sel_t;

    typedef struct packed {
        logic rsv_hi;
        logic timebase_request;
        logic pin1_request;
        logic pin0_request;
        logic timebase_irq_enable;
        logic pin1_irq_enable;
        logic pin0_irq_enable;
        logic global_irq_enable;
    } irq_first_t;

    typedef struct packed {
        logic power_switch_request;
        logic eeprom_request;
        logic cmp_a_request;
        logic cmp_p_request;
        logic power_switch_irq_enable;
        logic eeprom_irq_enable;
        logic cmp_a_irq_enable;
        logic cmp_p_irq_enable;
    } irq_second_t;

    typedef struct packed {
        logic [2:0] rsv_hi;
        logic monitor_request;
        logic [2:0] rsv_lo;
        logic monitor_irq_enable;
    } irq_third_t;

    typedef struct packed {
        logic timebase;
        logic power_switch;
        logic eeprom;
        logic cmp_a;
        logic cmp_p;
    } src_evt_t;
endpackage

// File: rtl/pin_sync_edge.sv
// two-stage synchroniser with selectable edge detection
`timescale 1ns/100ps
`default_nettype none
module pin_sync_edge
    import irq_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    input wire edge_mode_t edge_sel_i,
    output logic level_o,
    output logic evt_o
);
    logic meta;
    logic prev;
    // the first stage is read only by the second
    wire rise = level_o & ~prev;
    wire fall = ~level_o & prev;
    wire hit = (edge_sel_i[0] & rise) | (edge_sel_i[1] & fall);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= 1'b0;
            level_o <= 1'b0;
            prev <= 1'b0;
            evt_o <= 1'b0;
        end else begin
            meta <= async_i;
            level_o <= meta;
            prev <= level_o;
            evt_o <= hit;
        end
    end
endmodule
`default_nettype wire

// File: rtl/irq_flags_and_supply_monitor.sv
// interrupt flags, enables, priority grant and supply monitor control
// ----------------------------------------
// Summary of operation
// - low supply output bit 5 reads 1 while supply is below the level
// - monitor enable bit 4 switches the detector on, clearing switches it off
// - entering sleep forces the monitor off whatever the enable bit says
// - monitor request sets only after a delay from the output going high
// - in idle with monitor enabled, a supply drop sets its request and wakes
// - pin 1 edge field bits 3:2: off, rising, falling, both
// - pin 0 edge field bits 1:0 uses the same four codes
// - bit 0 of first control register is global enable; 0 blocks every source
// - first register: time base, pin 1, pin 0 flags 6..4, enables 3..1
// - second register flags: power switch 7, eeprom 6, cmp A 5, cmp P 4
// - second register enables: power switch 3, eeprom 2, cmp A 1, cmp P 0
// - every source has its own enable and its own request flag
// - unimplemented bits ignore writes and read as zero
// - third register: monitor request bit 4, monitor enable bit 0
// - flags set even when disabled; request needs source and global enable
// - servicing an interrupt clears the global enable and the serviced flag, other pending flags stay
// - any flag becoming set wakes the device from sleep or idle
// ----------------------------------------
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "irq_cfg.svh"
module irq_flags_and_supply_monitor
    import irq_pkg::*;
#(
    parameter int unsigned MON_IRQ_DELAY_CYCLES = `MON_IRQ_DELAY_CYC,
    parameter logic [23:0] PRIO_ORDER = `DEFAULT_PRIO
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [`AXI_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic ext_pin0_i,
    input wire logic ext_pin1_i,
    input wire logic low_supply_raw_i,
    input wire src_evt_t src_evt_i,
    input wire logic sleep_i,
    input wire logic idle_i,
    input wire logic irq_ack_i,
    output logic irq_req_o,
    output src_id_t irq_vec_o,
    output logic wake_o,
    output logic monitor_on_o,
    output trip_level_t trip_level_o
);
    // ----------------------------------------
    // register state
    // ----------------------------------------
    mon_ctrl_t mon_ctrl;
    edge_sel_t edge_sel;
    irq_first_t first_r;
    irq_second_t second_r;
    irq_third_t third_r;
    logic low_flag;
    mon_state_t mon_state;
    logic [`MON_CNT_W-1:0] mon_cnt;

    // ----------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------
    logic [2:0] sync_in;
    logic [2:0] sync_level;
    logic [2:0] sync_evt;
    edge_mode_t sync_sel [3];
    assign sync_in = {low_supply_raw_i, ext_pin1_i, ext_pin0_i};
    assign sync_sel[0] = edge_sel.pin0_edge_field;
    assign sync_sel[1] = edge_sel.pin1_edge_field;
    assign sync_sel[2] = EDGE_OFF;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            pin_sync_edge u_sync (
                .sys_clk_i(sys_clk_i),
                .rst_n_i(rst_n_i),
                .async_i(sync_in[gi]),
                .edge_sel_i(sync_sel[gi]),
                .level_o(sync_level[gi]),
                .evt_o(sync_evt[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    logic aw_have;
    logic w_have;
    logic [`AXI_ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
    wire w_take = s_axi_wvalid_i & s_axi_wready_o;
    wire do_wr = aw_have & w_have & ~s_axi_bvalid_o;
    wire next_aw_have = aw_take | (aw_have & ~do_wr);
    wire next_w_have = w_take | (w_have & ~do_wr);
    wire next_bvalid = do_wr | (s_axi_bvalid_o & ~s_axi_bready_i);
    wire ar_take = s_axi_arvalid_i & s_axi_arready_o;
    wire next_rvalid = ar_take | (s_axi_rvalid_o & ~s_axi_rready_i);

    wire hit_mon_w = aw_addr == `REG_MON_CTRL;
    wire hit_edge_w = aw_addr == `REG_EDGE_SEL;
    wire hit_first_w = aw_addr == `REG_IRQ_FIRST;
    wire hit_second_w = aw_addr == `REG_IRQ_SECOND;
    wire hit_third_w = aw_addr == `REG_IRQ_THIRD;
    wire w_mapped = hit_mon_w | hit_edge_w | hit_first_w | hit_second_w | hit_third_w;
    // only byte lane 0 carries register bits; other lanes are dropped
    wire wr_en = do_wr & w_lane0;
    wire wr_mon = wr_en & hit_mon_w;
    wire wr_edge = wr_en & hit_edge_w;
    wire wr_first = wr_en & hit_first_w;
    wire wr_second = wr_en & hit_second_w;
    wire wr_third = wr_en & hit_third_w;

    // unimplemented bits read as zero since they are never stored
    mon_ctrl_t mon_view;
    always_comb begin
        mon_view = mon_ctrl;
        mon_view.low_supply_output = low_flag;
    end
    wire hit_mon_r = s_axi_araddr_i == `REG_MON_CTRL;
    wire hit_edge_r = s_axi_araddr_i == `REG_EDGE_SEL;
    wire hit_first_r = s_axi_araddr_i == `REG_IRQ_FIRST;
    wire hit_second_r = s_axi_araddr_i == `REG_IRQ_SECOND;
    wire hit_third_r = s_axi_araddr_i == `REG_IRQ_THIRD;
    wire r_mapped = hit_mon_r | hit_edge_r | hit_first_r | hit_second_r | hit_third_r;
    wire [7:0] rd_byte = hit_mon_r ? mon_view : hit_edge_r ? edge_sel : hit_first_r ? first_r :
        hit_second_r ? second_r : hit_third_r ? third_r : `REG_RESET;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= '0;
            w_byte <= `REG_RESET;
            w_lane0 <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `RESP_OKAY;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rresp_o <= `RESP_OKAY;
            s_axi_rdata_o <= '0;
        end else begin
            aw_have <= next_aw_have;
            w_have <= next_w_have;
            if (aw_take) begin
                aw_addr <= s_axi_awaddr_i;
            end
            if (w_take) begin
                w_byte <= s_axi_wdata_i[7:0];
                w_lane0 <= s_axi_wstrb_i[0];
            end
            s_axi_awready_o <= ~next_aw_have & ~next_bvalid;
            s_axi_wready_o <= ~next_w_have & ~next_bvalid;
            s_axi_bvalid_o <= next_bvalid;
            if (do_wr) begin
                s_axi_bresp_o <= w_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
            s_axi_arready_o <= ~next_rvalid;
            s_axi_rvalid_o <= next_rvalid;
            if (ar_take) begin
                s_axi_rdata_o <= {24'h000000, rd_byte};
                s_axi_rresp_o <= r_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------
    // supply monitor
    // ----------------------------------------
    // the request waits out the delay so brief supply ripple near the level does not flood flags
    wire mon_done = mon_cnt == `MON_CNT_W'(MON_IRQ_DELAY_CYCLES - 1);
    wire mon_set = (mon_state == MON_COUNT) & low_flag & mon_done;
    mon_state_t next_mon_state;
    always_comb begin
        case (mon_state)
            MON_IDLE: next_mon_state = low_flag ? MON_COUNT : MON_IDLE;
            MON_COUNT: next_mon_state = !low_flag ? MON_IDLE : mon_done ? MON_FIRED : MON_COUNT;
            MON_FIRED: next_mon_state = low_flag ? MON_FIRED : MON_IDLE;
            default: next_mon_state = MON_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            monitor_on_o <= 1'b0;
            low_flag <= 1'b0;
            mon_state <= MON_IDLE;
            mon_cnt <= '0;
        end else begin
            monitor_on_o <= mon_ctrl.monitor_enable & ~sleep_i;
            low_flag <= monitor_on_o & sync_level[2];
            mon_state <= next_mon_state;
            mon_cnt <= (mon_state == MON_COUNT) ? mon_cnt + 1'b1 : '0;
        end
    end

    // ----------------------------------------
    // request flags, enables and grant
    // ----------------------------------------
    function automatic logic [`SRC_IDX_W:0] pick(input logic [`NUM_SRC-1:0] pend);
        logic [`SRC_IDX_W:0] res;
        logic [`SRC_IDX_W-1:0] idx;
        res = '0;
        for (int k = `NUM_SRC - 1; k >= 0; k--) begin
            idx = PRIO_ORDER[k*`SRC_IDX_W +: `SRC_IDX_W];
            if (pend[idx]) begin
                res = {1'b1, idx};
            end
        end
        return res;
    endfunction

    irq_first_t first_wr;
    irq_second_t second_wr;
    irq_third_t third_wr;
    assign first_wr = wr_first ? irq_first_t'(w_byte) : first_r;
    assign second_wr = wr_second ? irq_second_t'(w_byte) : second_r;
    assign third_wr = wr_third ? irq_third_t'(w_byte) : third_r;

    wire [`NUM_SRC-1:0] req_vec = {second_r.cmp_p_request, second_r.cmp_a_request, second_r.eeprom_request,
        third_r.monitor_request, second_r.power_switch_request, first_r.timebase_request,
        first_r.pin1_request, first_r.pin0_request};
    wire [`NUM_SRC-1:0] base_req = {second_wr.cmp_p_request, second_wr.cmp_a_request, second_wr.eeprom_request,
        third_wr.monitor_request, second_wr.power_switch_request, first_wr.timebase_request,
        first_wr.pin1_request, first_wr.pin0_request};
    wire [`NUM_SRC-1:0] next_en = {second_wr.cmp_p_irq_enable, second_wr.cmp_a_irq_enable,
        second_wr.eeprom_irq_enable, third_wr.monitor_irq_enable, second_wr.power_switch_irq_enable,
        first_wr.timebase_irq_enable, first_wr.pin1_irq_enable, first_wr.pin0_irq_enable};
    // flags set regardless of their enables
    wire [`NUM_SRC-1:0] set_vec = {src_evt_i.cmp_p, src_evt_i.cmp_a, src_evt_i.eeprom, mon_set,
        src_evt_i.power_switch, src_evt_i.timebase, sync_evt[1], sync_evt[0]};
    wire [`NUM_SRC-1:0] ack_clr = irq_ack_i ? (`NUM_SRC'(1) << irq_vec_o) : '0;
    // a set arriving with a clear wins
    wire [`NUM_SRC-1:0] next_req = (base_req & ~ack_clr) | set_vec;
    wire next_global = first_wr.global_irq_enable & ~irq_ack_i;
    wire [`SRC_IDX_W:0] grant = pick(next_req & next_en);
    wire any_new = |(set_vec & ~req_vec);

    irq_first_t next_first;
    irq_second_t next_second;
    irq_third_t next_third;
    always_comb begin
        next_first = first_wr;
        next_first.rsv_hi = 1'b0;
        next_first.global_irq_enable = next_global;
        next_first.pin0_request = next_req[SRC_PIN0];
        next_first.pin1_request = next_req[SRC_PIN1];
        next_first.timebase_request = next_req[SRC_TIMEBASE];
        next_second = second_wr;
        next_second.power_switch_request = next_req[SRC_POWER_SWITCH];
        next_second.eeprom_request = next_req[SRC_EEPROM];
        next_second.cmp_a_request = next_req[SRC_CMP_A];
        next_second.cmp_p_request = next_req[SRC_CMP_P];
        next_third = third_wr;
        next_third.rsv_hi = '0;
        next_third.rsv_lo = '0;
        next_third.monitor_request = next_req[SRC_MONITOR];
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mon_ctrl <= `REG_RESET;
            edge_sel <= `REG_RESET;
            first_r <= `REG_RESET;
            second_r <= `REG_RESET;
            third_r <= `REG_RESET;
            irq_req_o <= 1'b0;
            irq_vec_o <= SRC_PIN0;
            wake_o <= 1'b0;
            trip_level_o <= LVL_1V8;
        end else begin
            if (wr_mon) begin
                mon_ctrl.monitor_enable <= w_byte[4];
                mon_ctrl.trip_level_select <= trip_level_t'(w_byte[2:0]);
                trip_level_o <= trip_level_t'(w_byte[2:0]);
            end
            if (wr_edge) begin
                edge_sel.pin1_edge_field <= edge_mode_t'(w_byte[3:2]);
                edge_sel.pin0_edge_field <= edge_mode_t'(w_byte[1:0]);
            end
            first_r <= next_first;
            second_r <= next_second;
            third_r <= next_third;
            irq_req_o <= next_global & grant[`SRC_IDX_W];
            irq_vec_o <= src_id_t'(grant[`SRC_IDX_W-1:0]);
            wake_o <= (sleep_i | idle_i) & any_new;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_global_blocks: assert property (irq_req_o |-> first_r.global_irq_enable)
        else $error("request raised with global enable off");
    a_enable_needed: assert property (irq_req_o |-> req_vec[irq_vec_o] &&
        (($past(next_en) & (`NUM_SRC'(1) << irq_vec_o)) != '0))
        else $error("request granted for a disabled or idle source");
    a_ack_clears: assert property (irq_ack_i && !wr_first |=> !first_r.global_irq_enable && !irq_req_o)
        else $error("service did not clear global enable");
    a_sleep_off: assert property (sleep_i |=> !monitor_on_o ##1 !low_flag)
        else $error("monitor stayed on in sleep");
    a_monitor_on: assert property (mon_ctrl.monitor_enable && !sleep_i |=> monitor_on_o)
        else $error("monitor not switched on");
    a_low_output: assert property (monitor_on_o && sync_level[2] |=> low_flag)
        else $error("low supply output missed");
    // a preset request flag may already stand when the output rises, so only the set strobe is watched
    a_monitor_delay: assert property ($rose(low_flag) |-> !mon_set ##1
        !(mon_set && MON_IRQ_DELAY_CYCLES > 1))
        else $error("monitor request set before its delay");
    a_monitor_sets: assert property (mon_set |=> third_r.monitor_request)
        else $error("monitor request not recorded");
    a_pin_edge: assert property (sync_evt[0] |=> first_r.pin0_request)
        else $error("pin 0 edge not recorded");
    a_wake_flag: assert property ((sleep_i || idle_i) && any_new |=> wake_o)
        else $error("new flag did not wake the device");
    a_zero_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000)
        else $error("unimplemented bits read nonzero");
endmodule
`default_nettype wire

// File: tb/core_model.sv
// core model that services the granted interrupt
`timescale 1ns/100ps
`default_nettype none
module core_model
    import irq_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic svc_i,
    input wire logic irq_req_i,
    input wire src_id_t irq_vec_i,
    output logic irq_ack_o,
    output src_id_t served_o
);
    // ----------------------------------------
    // service
    // ----------------------------------------
    // ack lasts one cycle; the request drops right after, so no double service
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_ack_o <= 1'b0;
            served_o <= SRC_PIN0;
        end else begin
            irq_ack_o <= svc_i & irq_req_i & ~irq_ack_o;
            if (svc_i & irq_req_i & ~irq_ack_o) begin
                served_o <= irq_vec_i;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the interrupt flag and supply monitor block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top
    import irq_pkg::*;
;
    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic [1:0] s;} row_t;
    row_t rows[6] = '{'{8'h00, 8'hFF, 8'h17, 2'h0}, '{8'h04, 8'hFF, 8'h0F, 2'h0}, '{8'h08, 8'hFE, 8'h7E, 2'h0},
        '{8'h0C, 8'hFF, 8'hFF, 2'h0}, '{8'h10, 8'hFF, 8'h11, 2'h0}, '{8'h14, 8'hFF, 8'h00, 2'h2}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic pin0 = 1'b0, pin1 = 1'b0, raw = 1'b0, sleep = 1'b0, idle = 1'b0, svc = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, rd;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    src_evt_t evt = '0;
    logic awready, wready, bvalid, arready, rvalid, irq_req, ack, wake, mon_on;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata;
    src_id_t vec, served;
    trip_level_t trip;
    int errors = 0;
    int checks = 0;
    int wakes = 0;
    always #50 clk = ~clk;
    irq_flags_and_supply_monitor #(.MON_IRQ_DELAY_CYCLES(4)) dut_u (
        .sys_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ext_pin0_i(pin0),
        .ext_pin1_i(pin1), .low_supply_raw_i(raw), .src_evt_i(evt), .sleep_i(sleep), .idle_i(idle),
        .irq_ack_i(ack), .irq_req_o(irq_req), .irq_vec_o(vec), .wake_o(wake), .monitor_on_o(mon_on),
        .trip_level_o(trip));
    core_model core_u (.sys_clk_i(clk), .rst_n_i(rst_n), .svc_i(svc), .irq_req_i(irq_req), .irq_vec_i(vec),
        .irq_ack_o(ack), .served_o(served));
    // wake is a one-cycle pulse, so count the pulses for later inspection
    always @(posedge clk) if (wake === 1'b1) wakes <= wakes + 1;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awready === 1'b1) awv <= 1'b0;
            if (wready === 1'b1) wv <= 1'b0;
            if (bvalid === 1'b1) begin
                rsp = bresp;
                bready <= 1'b0;
            end
        end while (bvalid !== 1'b1 && n < 50);
        if (n >= 50) errors++;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        int n;
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arready === 1'b1) arv <= 1'b0;
            if (rvalid === 1'b1) begin
                rd = rdata[7:0];
                rsp = rresp;
                rready <= 1'b0;
            end
        end while (rvalid !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        `CHK(rd, e)
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rchk(rows[i].a, 8'h00);
            `CHK(rsp, rows[i].s)
        end
        $display("test done: reset values");
        for (int i = 0; i < 6; i++) begin
            wr(rows[i].a, rows[i].w);
            `CHK(rsp, rows[i].s)
            rchk(rows[i].a, rows[i].r);
            `CHK(irq_req, 1'b0)
        end
        for (int i = 0; i < 5; i++) wr(rows[i].a, 8'h00);
        $display("test done: register map");
        @(posedge clk) evt <= 5'h1F;
        @(posedge clk) evt <= '0;
        // flags are read/write, so every enable write carries the flags it keeps
        wr(8'h08, 8'h48);
        wr(8'h0C, 8'hF1);
        rchk(8'h08, 8'h48);
        rchk(8'h0C, 8'hF1);
        `CHK(irq_req, 1'b0)
        svc <= 1'b1;
        wr(8'h08, 8'h49);
        repeat (4) @(posedge clk);
        `CHK(served, SRC_TIMEBASE)
        rchk(8'h08, 8'h08);
        rchk(8'h0C, 8'hF1);
        wr(8'h08, 8'h09);
        repeat (4) @(posedge clk);
        `CHK(served, SRC_CMP_P)
        rchk(8'h0C, 8'hE1);
        svc <= 1'b0;
        wr(8'h0C, 8'h00);
        wr(8'h08, 8'h00);
        $display("test done: priority and service");
        for (int m = 0; m < 4; m++) begin
            wr(8'h04, {4'h0, m[1:0], m[1:0]});
            pin0 <= 1'b1;
            pin1 <= 1'b1;
            repeat (8) @(posedge clk);
            rchk(8'h08, m[0] ? 8'h30 : 8'h00);
            wr(8'h08, 8'h00);
            pin0 <= 1'b0;
            pin1 <= 1'b0;
            repeat (8) @(posedge clk);
            rchk(8'h08, m[1] ? 8'h30 : 8'h00);
            wr(8'h08, 8'h00);
        end
        $display("test done: pin edges");
        idle <= 1'b1;
        wr(8'h00, 8'h13);
        @(posedge clk);
        `CHK(trip, LVL_2V7)
        `CHK(mon_on, 1'b1)
        repeat (4) @(posedge clk); // settle before the output is trusted
        raw <= 1'b1;
        repeat (2) @(posedge clk);
        raw <= 1'b0;
        repeat (12) @(posedge clk);
        rchk(8'h10, 8'h00);
        `CHK(wakes, 0)
        raw <= 1'b1;
        repeat (12) @(posedge clk);
        rchk(8'h00, 8'h33);
        rchk(8'h10, 8'h10);
        `CHK(wakes, 1)
        sleep <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(mon_on, 1'b0)
        rchk(8'h00, 8'h13);
        sleep <= 1'b0;
        raw <= 1'b0;
        repeat (8) @(posedge clk);
        // request flag left set from before acts as the preset that mutes wake
        raw <= 1'b1;
        repeat (12) @(posedge clk);
        `CHK(wakes, 1)
        $display("test done: supply monitor");
        sleep <= 1'b1;
        @(posedge clk) evt <= 5'h10;
        @(posedge clk) evt <= '0;
        repeat (3) @(posedge clk);
        `CHK(wakes, 2)
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(trip, LVL_1V8)
        rst_n <= 1'b1;
        rchk(8'h10, 8'h00);
        $display("test done: sleep wake and mid-run reset");
        close_out();
    end
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        close_out();
    end
endmodule
`default_nettype wire
